/* File: verilog/alu_core.sv */
// Constants package and the combinational instruction datapath
package alu_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] INSTR_OFS = 8'h00;
	localparam logic [7:0] ACC_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] FADDR_OFS = 8'h0c;
	localparam logic [7:0] FDATA_OFS = 8'h10;
	localparam logic [7:0] WDT_OFS = 8'h14;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OP_LSB = 0;
	localparam int DEST_BIT = 3;
	localparam int FADDR_LSB = 8;
	localparam int LIT_LSB = 16;
	localparam int CARRY_BIT = 0;
	localparam int HALF_BIT = 1;
	localparam int ZERO_BIT = 2;
	localparam int PD_BIT = 3;
	localparam int TO_BIT = 4;
	localparam int SLEEP_BIT = 5;
	localparam int WAKE_BIT = 8;
	localparam int PRE_LSB = 8;
	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [31:0] INSTR_RST = 32'h0000_0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic PD_RST = 1'b1;
	localparam logic TO_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		power_down_op = 3'h0,
		literal_minus_acc_op = 3'h1,
		file_minus_acc_op = 3'h2,
		rotate_right_carry_op = 3'h3,
		nibble_exchange_op = 3'h4,
		literal_xor_op = 3'h5,
		file_xor_op = 3'h6,
		unused_op = 3'h7
	} op_t;
endpackage : alu_pkg

`timescale 1ns/1ps
// ----------------------------------------------------------------
// Datapath
// ----------------------------------------------------------------
module alu_core (
	input wire alu_pkg::op_t i_op,
	input wire logic [7:0] i_lit,
	input wire logic [7:0] i_acc,
	input wire logic [7:0] i_fval,
	input wire logic i_dest,
	input wire logic i_carry,
	input wire logic i_half,
	input wire logic i_zero,
	output logic [7:0] o_result,
	output logic o_carry,
	output logic o_half,
	output logic o_zero,
	output logic o_wr_acc,
	output logic o_wr_file,
	output logic o_sleep
);
	// Subtract b from a: {no borrow, no nibble borrow, difference}
	function automatic logic [9:0] subtract(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] d;
		d = a - b;
		return {a >= b, a[3:0] >= b[3:0], d};
	endfunction : subtract

	// Result, flags and destination per operation
	always_comb begin
		logic [9:0] s;
		s = 10'h000;
		o_result = i_acc;
		o_carry = i_carry;
		o_half = i_half;
		o_zero = i_zero;
		o_wr_acc = 1'b0;
		o_wr_file = 1'b0;
		o_sleep = 1'b0;
		unique case (i_op)
			alu_pkg::power_down_op: begin
				o_sleep = 1'b1;
			end
			alu_pkg::literal_minus_acc_op: begin
				s = subtract(i_lit, i_acc);
				{o_carry, o_half, o_result} = s;
				o_zero = (s[7:0] == 8'h00);
				o_wr_acc = 1'b1;
			end
			alu_pkg::file_minus_acc_op: begin
				s = subtract(i_fval, i_acc);
				{o_carry, o_half, o_result} = s;
				o_zero = (s[7:0] == 8'h00);
				o_wr_acc = ~i_dest;
				o_wr_file = i_dest;
			end
			alu_pkg::rotate_right_carry_op: begin
				o_result = {i_carry, i_fval[7:1]};
				o_carry = i_fval[0];
				o_wr_acc = ~i_dest;
				o_wr_file = i_dest;
			end
			alu_pkg::nibble_exchange_op: begin
				o_result = {i_fval[3:0], i_fval[7:4]};
				o_wr_acc = ~i_dest;
				o_wr_file = i_dest;
			end
			alu_pkg::literal_xor_op: begin
				o_result = i_acc ^ i_lit;
				o_zero = ((i_acc ^ i_lit) == 8'h00);
				o_wr_acc = 1'b1;
			end
			alu_pkg::file_xor_op: begin
				o_result = i_acc ^ i_fval;
				o_zero = ((i_acc ^ i_fval) == 8'h00);
				o_wr_acc = ~i_dest;
				o_wr_file = i_dest;
			end
			default: begin
				o_result = i_acc;
			end
		endcase
	end
endmodule : alu_core

/* File: verilog/alu_sleep_exec.sv */
// Instruction execution unit with AXI4-Lite register access
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module alu_sleep_exec #(
	parameter int PRE_W = 8,
	parameter int FILE_DEPTH = 128
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_sleep
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] instr_q;
	logic [7:0] acc_q;
	logic carry_q, half_q, zero_q, pd_q, to_q, sleep_q;
	logic [6:0] faddr_q;
	logic [7:0] fmem [FILE_DEPTH];
	logic [PRE_W-1:0] pre_q;
	logic [7:0] wdt_q;
	logic wr_fire, exec, exec_sleep, wake, wdt_ovf;
	logic [31:0] instr_w;
	logic [6:0] fsel;
	logic [7:0] fval;
	alu_pkg::op_t op;
	logic [7:0] alu_res;
	logic alu_c, alu_h, alu_z, alu_wa, alu_wf, alu_sl;

	// Address decode shared by both channels
	function automatic logic mapped(input logic [7:0] a);
		return a == alu_pkg::INSTR_OFS || a == alu_pkg::ACC_OFS ||
			a == alu_pkg::STATUS_OFS || a == alu_pkg::FADDR_OFS ||
			a == alu_pkg::FDATA_OFS || a == alu_pkg::WDT_OFS;
	endfunction : mapped

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	// Both halves held, answer not yet given
	assign wr_fire = !o_awready && !o_wready && !o_bvalid;

	// Address and data taken in either order
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= alu_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				o_awready <= 1'b0;
				awaddr_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				o_wready <= 1'b0;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			if (wr_fire) begin
				o_bvalid <= 1'b1;
				o_bresp <= mapped(awaddr_q) ? alu_pkg::RESP_OKAY :
					alu_pkg::RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= alu_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= mapped(i_araddr) ? alu_pkg::RESP_OKAY :
				alu_pkg::RESP_SLVERR;
			unique case (i_araddr)
				alu_pkg::INSTR_OFS: o_rdata <= instr_q;
				alu_pkg::ACC_OFS: o_rdata <= {24'h000000, acc_q};
				alu_pkg::STATUS_OFS: o_rdata <= {26'h0000000,
					sleep_q, to_q, pd_q, zero_q, half_q, carry_q};
				alu_pkg::FADDR_OFS: o_rdata <= {25'h0000000, faddr_q};
				alu_pkg::FDATA_OFS: o_rdata <= {24'h000000,
					fmem[faddr_q]};
				alu_pkg::WDT_OFS: o_rdata <= {16'h0000,
					8'(pre_q), wdt_q};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Instruction issue
	// ----------------------------------------------------------------
	// Byte lanes merged into the instruction word
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			instr_w[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] :
				instr_q[8*i +: 8];
		end
	end

	// A write to the instruction word runs it, unless asleep
	assign exec = wr_fire && awaddr_q == alu_pkg::INSTR_OFS && !sleep_q;
	assign op = alu_pkg::op_t'(instr_w[alu_pkg::OP_LSB +: 3]);
	assign fsel = instr_w[alu_pkg::FADDR_LSB +: 7];
	assign fval = fmem[fsel];
	assign exec_sleep = exec && alu_sl;
	assign wake = wr_fire && awaddr_q == alu_pkg::STATUS_OFS &&
		wstrb_q[1] && wdata_q[alu_pkg::WAKE_BIT];

	alu_core u_alu (
		.i_op(op),
		.i_lit(instr_w[alu_pkg::LIT_LSB +: 8]),
		.i_acc(acc_q),
		.i_fval(fval),
		.i_dest(instr_w[alu_pkg::DEST_BIT]),
		.i_carry(carry_q),
		.i_half(half_q),
		.i_zero(zero_q),
		.o_result(alu_res),
		.o_carry(alu_c),
		.o_half(alu_h),
		.o_zero(alu_z),
		.o_wr_acc(alu_wa),
		.o_wr_file(alu_wf),
		.o_sleep(alu_sl)
	);

	// Instruction word holding register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			instr_q <= alu_pkg::INSTR_RST;
		end else if (wr_fire && awaddr_q == alu_pkg::INSTR_OFS) begin
			instr_q <= instr_w;
		end
	end

	// ----------------------------------------------------------------
	// Accumulator, arithmetic flags and file registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc_q <= alu_pkg::ACC_RST;
		end else if (exec && alu_wa) begin
			acc_q <= alu_res;
		end else if (wr_fire && awaddr_q == alu_pkg::ACC_OFS &&
			wstrb_q[0]) begin
			acc_q <= wdata_q[7:0];
		end
	end

	// Flags follow the datapath, which keeps unaffected ones
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			carry_q <= 1'b0;
			half_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (exec) begin
			carry_q <= alu_c;
			half_q <= alu_h;
			zero_q <= alu_z;
		end else if (wr_fire && awaddr_q == alu_pkg::STATUS_OFS &&
			wstrb_q[0]) begin
			carry_q <= wdata_q[alu_pkg::CARRY_BIT];
			half_q <= wdata_q[alu_pkg::HALF_BIT];
			zero_q <= wdata_q[alu_pkg::ZERO_BIT];
		end
	end

	// File address pointer for direct software access
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			faddr_q <= 7'h00;
		end else if (wr_fire && awaddr_q == alu_pkg::FADDR_OFS &&
			wstrb_q[0]) begin
			faddr_q <= wdata_q[6:0];
		end
	end

	// File register array, contents not reset
	always_ff @(posedge i_clk) begin
		if (exec && alu_wf) begin
			fmem[fsel] <= alu_res;
		end else if (wr_fire && awaddr_q == alu_pkg::FDATA_OFS &&
			wstrb_q[0]) begin
			fmem[faddr_q] <= wdata_q[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Watchdog, power flags and sleep
	// ----------------------------------------------------------------
	assign wdt_ovf = (&pre_q) && (&wdt_q) && !exec_sleep;

	// Prescaler feeds the counter; power-down clears both
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pre_q <= '0;
			wdt_q <= alu_pkg::WDT_CLEAR;
		end else if (exec_sleep) begin
			pre_q <= '0;
			wdt_q <= alu_pkg::WDT_CLEAR;
		end else begin
			pre_q <= pre_q + 1'b1;
			if (&pre_q) begin
				wdt_q <= wdt_q + 8'h01;
			end
		end
	end

	// Status bits of the power-down sequence
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pd_q <= alu_pkg::PD_RST;
			to_q <= alu_pkg::TO_RST;
		end else if (exec_sleep) begin
			pd_q <= 1'b0;
			to_q <= 1'b1;
		end else if (wdt_ovf) begin
			to_q <= 1'b0;
		end
	end

	// Sleep until software wakes or the watchdog expires
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sleep_q <= 1'b0;
		end else if (exec_sleep) begin
			sleep_q <= 1'b1;
		end else if (wake || wdt_ovf) begin
			sleep_q <= 1'b0;
		end
	end

	assign o_sleep = sleep_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_sleep_issue;
		exec && op == alu_pkg::power_down_op;
	endsequence
	sequence s_sleep_done;
		!pd_q && to_q && sleep_q && wdt_q == 8'h00;
	endsequence

	property p_sleep_flags;
		s_sleep_issue |=> s_sleep_done;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags)
		else $error("power-down flags wrong");

	property p_wdt_clear;
		s_sleep_issue |=> pre_q == '0 ##1 pre_q == 1;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear)
		else $error("watchdog not cleared");

	property p_sleep_hold;
		sleep_q && !wake && !wdt_ovf |=> sleep_q && !exec;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("sleep left without cause");

	property p_lit_sub;
		exec && op == alu_pkg::literal_minus_acc_op |=>
			acc_q == 8'($past(instr_w[23:16]) - $past(acc_q)) &&
			carry_q == ($past(instr_w[23:16]) >= $past(acc_q)) &&
			zero_q == (acc_q == 8'h00);
	endproperty
	a_lit_sub: assert property (p_lit_sub)
		else $error("literal subtract wrong");

	property p_rotate;
		exec && op == alu_pkg::rotate_right_carry_op |=>
			carry_q == $past(fval[0]) && $stable(zero_q) &&
			$stable(half_q);
	endproperty
	a_rotate: assert property (p_rotate)
		else $error("rotate flags wrong");

	property p_dest_acc;
		exec && alu_wa && op != alu_pkg::literal_minus_acc_op &&
			op != alu_pkg::literal_xor_op |-> !instr_w[3] && !alu_wf;
	endproperty
	a_dest_acc: assert property (p_dest_acc)
		else $error("destination select wrong");

	property p_file_sub;
		exec && op == alu_pkg::file_minus_acc_op |=>
			half_q == ($past(fval[3:0]) >= $past(acc_q[3:0])) &&
			carry_q == ($past(fval) >= $past(acc_q));
	endproperty
	a_file_sub: assert property (p_file_sub)
		else $error("file subtract flags wrong");

	property p_swap;
		exec && op == alu_pkg::nibble_exchange_op |->
			alu_res == {fval[3:0], fval[7:4]} ##1
			$stable(carry_q) && $stable(zero_q) && $stable(half_q);
	endproperty
	a_swap: assert property (p_swap)
		else $error("nibble exchange wrong");

	property p_lit_xor;
		exec && op == alu_pkg::literal_xor_op |=>
			acc_q == ($past(acc_q) ^ $past(instr_w[23:16])) &&
			$stable(carry_q) && zero_q == (acc_q == 8'h00);
	endproperty
	a_lit_xor: assert property (p_lit_xor)
		else $error("literal xor wrong");

	property p_file_xor;
		exec && op == alu_pkg::file_xor_op |=>
			$stable(carry_q) && $stable(half_q) &&
			zero_q == (($past(acc_q) ^ $past(fval)) == 8'h00);
	endproperty
	a_file_xor: assert property (p_file_xor)
		else $error("file xor flags wrong");
endmodule : alu_sleep_exec

/* File: bench/tb_top.sv */
// Self-checking bench for the instruction execution unit
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	localparam alu_pkg::op_t lit_sub = alu_pkg::literal_minus_acc_op;
	localparam alu_pkg::op_t file_sub = alu_pkg::file_minus_acc_op;
	localparam alu_pkg::op_t rot_r = alu_pkg::rotate_right_carry_op;
	localparam alu_pkg::op_t nib_x = alu_pkg::nibble_exchange_op;
	localparam alu_pkg::op_t lit_xor = alu_pkg::literal_xor_op;
	localparam alu_pkg::op_t file_xor = alu_pkg::file_xor_op;
	localparam logic [1:0] okay = alu_pkg::RESP_OKAY;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_awaddr = 8'h00;
	logic i_awvalid = 1'b0;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'h0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic [7:0] i_araddr = 8'h00;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sleep;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata, rd;
	int fail_count = 0;
	int n_compared = 0;

	alu_sleep_exec #(.PRE_W(8), .FILE_DEPTH(128)) i_alu_sleep_exec (
		.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_sleep(o_sleep)
	);

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic timed_out(input string what);
		fail_count++;
		$display("MISMATCH %s expected handshake seen none", what);
		close_out();
	endtask : timed_out

	// ----------------------------------------------------------------
	// Bus tasks: ready and answers sampled at the rising edge
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] exp_resp);
		logic aw_done, w_done, b_done;
		logic [1:0] resp;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		resp = 2'h3;
		@(posedge i_clk);
		i_awaddr <= a;
		i_awvalid <= 1'b1;
		i_wdata <= d;
		i_wstrb <= s;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 100 && !b_done; n++) begin
			@(posedge i_clk);
			// Values seen here are those the edge sampled
			if (!aw_done && o_awready) begin
				aw_done = 1'b1;
				i_awvalid <= 1'b0;
			end
			if (!w_done && o_wready) begin
				w_done = 1'b1;
				i_wvalid <= 1'b0;
			end
			if (o_bvalid) begin
				b_done = 1'b1;
				resp = o_bresp;
				i_bready <= 1'b0;
			end
		end
		if (!b_done) timed_out("write");
		chk("bresp", {30'h0, exp_resp}, {30'h0, resp});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] exp_resp,
		output logic [31:0] d);
		logic a_done, r_done;
		logic [1:0] resp;
		int n;
		a_done = 1'b0;
		r_done = 1'b0;
		resp = 2'h3;
		d = 32'h0;
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 100 && !r_done; n++) begin
			@(posedge i_clk);
			// Data taken at the edge that sees rvalid high
			if (!a_done && o_arready) begin
				a_done = 1'b1;
				i_arvalid <= 1'b0;
			end
			if (o_rvalid) begin
				r_done = 1'b1;
				d = o_rdata;
				resp = o_rresp;
				i_rready <= 1'b0;
			end
		end
		if (!r_done) timed_out("read");
		chk("rresp", {30'h0, exp_resp}, {30'h0, resp});
	endtask : axi_rd

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] v;
		axi_rd(a, okay, v);
		chk(what, exp, v);
	endtask : rd_chk

	// Loads operands, executes one instruction and reads back the results
	task automatic run(input alu_pkg::op_t op, input logic d,
		input logic [6:0] fa, input logic [7:0] lit, input logic [7:0] acc,
		input logic [7:0] fv, input logic [2:0] st, input logic [7:0] e_acc,
		input logic [7:0] e_file, input logic [5:0] e_st);
		axi_wr(alu_pkg::ACC_OFS, {24'h0, acc}, 4'h1, okay);
		axi_wr(alu_pkg::FADDR_OFS, {25'h0, fa}, 4'h1, okay);
		axi_wr(alu_pkg::FDATA_OFS, {24'h0, fv}, 4'h1, okay);
		axi_wr(alu_pkg::STATUS_OFS, {29'h0, st}, 4'h1, okay);
		axi_wr(alu_pkg::INSTR_OFS, {8'h00, lit, 1'b0, fa, 4'h0, d, op},
			4'hf, okay);
		rd_chk("acc", alu_pkg::ACC_OFS, {24'h0, e_acc});
		rd_chk("file", alu_pkg::FDATA_OFS, {24'h0, e_file});
		rd_chk("status", alu_pkg::STATUS_OFS, {26'h0, e_st});
	endtask : run

	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		chk("sleep_rst", 32'h0, {31'h0, o_sleep});
		rd_chk("status_rst", alu_pkg::STATUS_OFS, 32'h18);
		run(lit_sub, 1'b0, 7'h00, 8'h35, 8'h35, 8'h00, 3'h0, 8'h00, 8'h00, 6'h1f);
		run(lit_sub, 1'b0, 7'h00, 8'h10, 8'h21, 8'h00, 3'h7, 8'hef, 8'h00, 6'h18);
		run(file_sub, 1'b0, 7'h7f, 8'h00, 8'h01, 8'h80, 3'h0, 8'h7f, 8'h80, 6'h19);
		run(file_sub, 1'b1, 7'h7f, 8'h00, 8'h01, 8'h80, 3'h0, 8'h01, 8'h7f, 6'h19);
		run(rot_r, 1'b1, 7'h05, 8'h00, 8'h00, 8'h02, 3'h7, 8'h00, 8'h81, 6'h1e);
		run(rot_r, 1'b0, 7'h05, 8'h00, 8'h00, 8'h01, 3'h0, 8'h00, 8'h01, 6'h19);
		run(nib_x, 1'b0, 7'h10, 8'h00, 8'h00, 8'ha5, 3'h5, 8'h5a, 8'ha5, 6'h1d);
		run(nib_x, 1'b1, 7'h10, 8'h00, 8'h00, 8'h3c, 3'h2, 8'h00, 8'hc3, 6'h1a);
		run(lit_xor, 1'b0, 7'h00, 8'h3c, 8'h3c, 8'h00, 3'h3, 8'h00, 8'h00, 6'h1f);
		run(lit_xor, 1'b0, 7'h00, 8'hff, 8'h0f, 8'h00, 3'h4, 8'hf0, 8'h00, 6'h18);
		run(file_xor, 1'b1, 7'h00, 8'h00, 8'h55, 8'h55, 3'h0, 8'h55, 8'h00, 6'h1c);
		run(file_xor, 1'b0, 7'h00, 8'h00, 8'h0f, 8'hf0, 3'h7, 8'hff, 8'hf0, 6'h1b);
		// Let the watchdog advance, then power down
		repeat (600) @(posedge i_clk);
		axi_rd(alu_pkg::WDT_OFS, okay, rd);
		chk("wdt_running", 32'h1, {31'h0, rd[7:0] != 8'h00});
		axi_wr(alu_pkg::STATUS_OFS, 32'h0, 4'h1, okay);
		axi_wr(alu_pkg::ACC_OFS, 32'h42, 4'h1, okay);
		axi_wr(alu_pkg::INSTR_OFS, {29'h0, alu_pkg::power_down_op}, 4'hf, okay);
		@(negedge i_clk);
		chk("sleep", 32'h1, {31'h0, o_sleep});
		rd_chk("status_pd", alu_pkg::STATUS_OFS, 32'h30);
		axi_rd(alu_pkg::WDT_OFS, okay, rd);
		chk("wdt_count", 32'h0, {24'h0, rd[7:0]});
		chk("wdt_pre", 32'h1, {31'h0, rd[15:8] < 8'h40});
		// Execution is refused while asleep
		axi_wr(alu_pkg::INSTR_OFS, {8'h00, 8'hff, 13'h0, lit_xor}, 4'hf, okay);
		rd_chk("acc_sleep", alu_pkg::ACC_OFS, 32'h42);
		axi_wr(alu_pkg::STATUS_OFS, 32'h100, 4'h2, okay);
		@(negedge i_clk);
		chk("awake", 32'h0, {31'h0, o_sleep});
		rd_chk("status_wake", alu_pkg::STATUS_OFS, 32'h10);
		// Unmapped address answers with an error and changes nothing
		axi_wr(8'h3c, 32'hffff_ffff, 4'hf, alu_pkg::RESP_SLVERR);
		axi_rd(8'h3c, alu_pkg::RESP_SLVERR, rd);
		chk("unmapped_rd", 32'h0, rd);
		rd_chk("acc_after", alu_pkg::ACC_OFS, 32'h42);
		close_out();
	end
endmodule : tb_top
